// ==== core/cacv_top.sv ====
// Character attribute and cursor video logic with AHB-Lite registers.
// Assumes cells, frame start and command strobes arrive on this clock;
// only the light pen pin is asynchronous.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
module cacv_top (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 srst,
  // AHB-Lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // Frame timing and character cells
  input  wire logic                 frame_start,
  input  wire cacv_pkg::cacv_char_t char_in,
  input  wire logic                 light_pen_in,
  // Video toward the character generator
  output cacv_pkg::cacv_video_t     video_out,
  output logic                      pen_cursor_mark
);

  // Bus address phase capture
  logic                         wr_pend;
  logic [7:0]                   wr_addr;
  // Pending and active configuration
  cacv_pkg::cacv_attr_t         attr_pend;
  cacv_pkg::cacv_attr_t         attr_cfg;
  cacv_pkg::cacv_cursor_t       cur_pend;
  cacv_pkg::cacv_cursor_t       cur_cfg;
  logic [4:0]                   ul1_line;
  logic [4:0]                   ul2_line;
  // Blink phase counters in frames
  logic [6:0]                   char_phase;
  logic [6:0]                   cur_phase;
  logic                         char_blink_on;
  logic                         cur_blink_on;
  // Light pen synchroniser and sticky hits
  logic                         pen_meta;
  logic                         pen_sync;
  logic [1:0]                   pen_hit;
  // Attribute decode
  logic                         ul1_hit;
  logic                         ul2_ctl;
  logic                         ul2_hit;
  logic                         inv_hit;
  logic                         abs_hit;
  logic                         cur1_show;
  logic                         cur2_show;
  logic                         next_blank;
  logic                         next_reverse;
  logic [4:0]                   next_line;
  logic [14:0]                  next_data;
  logic [1:0]                   pen_now;

  // Character word bit picked by a select field, off for 15
  function automatic logic pick_bit(input logic [14:0] word, input logic [3:0] sel);
    logic r;
    r = 1'b0;
    if (sel != cacv_pkg::SEL_OFF)
    begin
      r = word[sel];
    end
    return r;
  endfunction

  // On phase of a blink period of four times rate frames
  function automatic logic blink_on(input logic [6:0] phase, input logic [4:0] rate,
                                    input logic [1:0] duty);
    logic [6:0] quarter;
    logic       r;
    quarter = {2'b00, rate};
    case (duty)
      cacv_pkg::DUTY_ALWAYS: r = 1'b1;
      cacv_pkg::DUTY_25:     r = phase < quarter;
      cacv_pkg::DUTY_50:     r = phase < 7'(2 * quarter);
      cacv_pkg::DUTY_75:     r = phase < 7'(3 * quarter);
      default:               r = 1'b1;
    endcase
    return r;
  endfunction

  // Next phase, wrapping after four times rate frames
  function automatic logic [6:0] phase_step(input logic [6:0] phase, input logic [4:0] rate);
    logic [6:0] last;
    logic [6:0] r;
    last = 7'({rate, 2'b00} - 7'd1);
    if (rate == 5'd0 || phase >= last)
    begin
      r = 7'd0;
    end
    else
    begin
      r = phase + 7'd1;
    end
    return r;
  endfunction

  // Cursor config from a bus word; bit 7 stays unused so each
  // cursor's four controls sit on their own hex digit
  function automatic cacv_pkg::cacv_cursor_t cur_unpack(input logic [31:0] d);
    cacv_pkg::cacv_cursor_t r;
    r      = '0;
    r.rate = d[cacv_pkg::CUR_RATE_POS +: 5];
    r.duty = d[cacv_pkg::CUR_DUTY_POS +: 2];
    r.cur1 = d[cacv_pkg::CUR1_POS +: 4];
    r.cur2 = d[cacv_pkg::CUR2_POS +: 4];
    return r;
  endfunction

  // Bus word from a cursor config, the inverse of cur_unpack
  // Keeps read-back on the same layout as writes
  function automatic logic [31:0] cur_pack(input cacv_pkg::cacv_cursor_t c);
    logic [31:0] r;
    r                              = 32'h0000_0000;
    r[cacv_pkg::CUR_RATE_POS +: 5] = c.rate;
    r[cacv_pkg::CUR_DUTY_POS +: 2] = c.duty;
    r[cacv_pkg::CUR1_POS +: 4]     = c.cur1;
    r[cacv_pkg::CUR2_POS +: 4]     = c.cur2;
    return r;
  endfunction

  // Single-cycle slave: never stalls, always OKAY
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Address phase capture for writes
  // Write data follows one cycle later, so the decode is kept until then
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend <= hsel & htrans[1] & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // Read data launched from the address phase, zero when unmapped
  // Reads see staged config, not what the current frame uses
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      case (haddr[7:0])
        cacv_pkg::OFS_ATTR:   hrdata <= {7'h00, attr_pend};
        cacv_pkg::OFS_CURSOR: hrdata <= cur_pack(cur_pend);
        cacv_pkg::OFS_ROW:    hrdata <= {19'h0_0000, ul2_line, 3'b000, ul1_line};
        cacv_pkg::OFS_STATUS: hrdata <= {28'h000_0000, cur_blink_on, char_blink_on,
                                         pen_hit};
        default:              hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // config-only select fields
  // Global config writes stage here until the next frame start
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      attr_pend <= cacv_pkg::cacv_attr_t'(cacv_pkg::ATTR_RST[24:0]);
      cur_pend  <= cur_unpack(cacv_pkg::CURSOR_RST);
    end
    else if (wr_pend && wr_addr == cacv_pkg::OFS_ATTR)
    begin
      attr_pend <= cacv_pkg::cacv_attr_t'(hwdata[24:0]);
    end
    else if (wr_pend && wr_addr == cacv_pkg::OFS_CURSOR)
    begin
      cur_pend <= cur_unpack(hwdata);
    end
  end

  // per-frame parameter load
  // Committing at frame start avoids tearing mid frame
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      attr_cfg <= cacv_pkg::cacv_attr_t'(cacv_pkg::ATTR_RST[24:0]);
      cur_cfg  <= cur_unpack(cacv_pkg::CURSOR_RST);
    end
    else if (frame_start)
    begin
      attr_cfg <= attr_pend;
      cur_cfg  <= cur_pend;
    end
  end

  // row descriptor reload
  // Row descriptor only touches the two underline lines
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ul1_line <= cacv_pkg::LINE_RST;
      ul2_line <= cacv_pkg::LINE_RST;
    end
    else if (wr_pend && wr_addr == cacv_pkg::OFS_ROW)
    begin
      ul1_line <= hwdata[cacv_pkg::ROW_UL1_POS +: 5];
      ul2_line <= hwdata[cacv_pkg::ROW_UL2_POS +: 5];
    end
  end

  // Rate zero parks the phase, so quarter duties stay dark
  // frame-based blink period
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      char_phase <= 7'd0;
      cur_phase  <= 7'd0;
    end
    else if (frame_start)
    begin
      char_phase <= phase_step(char_phase, attr_cfg.rate);
      cur_phase  <= phase_step(cur_phase, cur_cfg.rate);
    end
  end

  assign char_blink_on = blink_on(char_phase, attr_cfg.rate, attr_cfg.duty);
  assign cur_blink_on  = blink_on(cur_phase, cur_cfg.rate, cur_cfg.duty);

  // Two-flop pen synchroniser; first stage feeds only the second
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pen_meta <= 1'b0;
      pen_sync <= 1'b0;
    end
    else
    begin
      pen_meta <= light_pen_in;
      pen_sync <= pen_meta;
    end
  end

  assign ul1_hit = pick_bit(char_in.word, attr_cfg.ul1_sel)
                 & (char_in.scan_line == ul1_line);
  assign inv_hit = pick_bit(char_in.word, attr_cfg.inv_sel);
  assign abs_hit = pick_bit(char_in.word, attr_cfg.abs_sel);
  assign ul2_ctl = (attr_cfg.ul2_sel == cacv_pkg::SEL_OFF) ? 1'b0 :
                   attr_cfg.gpa_ul2 ? char_in.gpa :
                   pick_bit(char_in.word, attr_cfg.ul2_sel);
  assign ul2_hit = ul2_ctl & (char_in.scan_line == ul2_line)
                 & (!attr_cfg.blink_ul | char_blink_on);
  assign cur1_show = char_in.cur1 & (!cur_cfg.cur1.blink_en | cur_blink_on);
  assign cur2_show = char_in.cur2 & (!cur_cfg.cur2.blink_en | cur_blink_on);
  // pen seen on a detecting cursor
  assign pen_now = {cur_cfg.cur2.pen_detect & char_in.cur2,
                    cur_cfg.cur1.pen_detect & char_in.cur1} & {2{pen_sync & char_in.valid}};

  // Output attribute combine for this cell
  always_comb
  begin
    next_blank = char_in.blank | ul1_hit | ul2_hit | inv_hit
               | (cur1_show & !cur_cfg.cur1.reverse_en)
               | (cur2_show & !cur_cfg.cur2.reverse_en);
    // inversion sources; invisible not among them
    next_reverse = char_in.reverse ^ ul1_hit ^ ul2_hit
                 ^ (cur1_show & cur_cfg.cur1.reverse_en)
                 ^ (cur2_show & cur_cfg.cur2.reverse_en);
    next_line = abs_hit ? char_in.abs_line : char_in.line_count;
    next_data = char_in.word;
    if (cur_cfg.cur1.out_en)
    begin
      next_data[14] = cur1_show;
    end
    if (cur_cfg.cur2.out_en)
    begin
      next_data[13] = cur2_show;
    end
  end

  // Registered video toward the character generator
  // Idle slots go out as all zero so stale attributes never leak
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      video_out <= '0;
    end
    else
    begin
      video_out.valid      <= char_in.valid;
      video_out.data       <= char_in.valid ? next_data : 15'h0000;
      video_out.line_count <= char_in.valid ? next_line : 5'h00;
      video_out.reverse    <= char_in.valid & next_reverse;
      video_out.blank      <= char_in.valid & next_blank;
    end
  end

  // A clear racing a new hit keeps the hit, so no pen event is lost
  // pen mark and sticky hit, set beats clear
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pen_cursor_mark <= 1'b0;
      pen_hit         <= 2'b00;
    end
    else
    begin
      pen_cursor_mark <= |pen_now;
      if (wr_pend && wr_addr == cacv_pkg::OFS_STATUS)
      begin
        pen_hit <= (pen_hit & ~hwdata[1:0]) | pen_now;
      end
      else
      begin
        pen_hit <= pen_hit | pen_now;
      end
    end
  end

endmodule

// ==== core/cacv_pkg.sv ====
// Package for the character attribute and cursor video block.
// Assumes one character clock domain and an AHB-Lite register port.
package cacv_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_ATTR   = 8'h00;
  localparam logic [7:0] OFS_CURSOR = 8'h04;
  localparam logic [7:0] OFS_ROW    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  // Bit select value that turns an attribute off
  localparam logic [3:0] SEL_OFF    = 4'hf;
  // Attribute config field positions
  localparam int ATTR_UL1_POS  = 0;
  localparam int ATTR_UL2_POS  = 4;
  localparam int ATTR_INV_POS  = 8;
  localparam int ATTR_ABS_POS  = 12;
  localparam int ATTR_BUE_POS  = 16;
  localparam int ATTR_RATE_POS = 17;
  localparam int ATTR_DUTY_POS = 22;
  localparam int ATTR_GPA_POS  = 24;
  // Cursor config field positions
  localparam int CUR_RATE_POS  = 0;
  localparam int CUR_DUTY_POS  = 5;
  localparam int CUR1_POS      = 8;
  localparam int CUR2_POS      = 12;
  // Row descriptor field positions
  localparam int ROW_UL1_POS   = 0;
  localparam int ROW_UL2_POS   = 8;
  // Reset values
  localparam logic [31:0] ATTR_RST   = 32'h0000_ffff;
  localparam logic [31:0] CURSOR_RST = 32'h0000_0000;
  localparam logic [4:0]  LINE_RST   = 5'h00;
  // Duty cycle codes
  localparam logic [1:0] DUTY_ALWAYS = 2'b00;
  localparam logic [1:0] DUTY_25     = 2'b01;
  localparam logic [1:0] DUTY_50     = 2'b10;
  localparam logic [1:0] DUTY_75     = 2'b11;

  typedef struct packed {
    logic       gpa_ul2;
    logic [1:0] duty;
    logic [4:0] rate;
    logic       blink_ul;
    logic [3:0] abs_sel;
    logic [3:0] inv_sel;
    logic [3:0] ul2_sel;
    logic [3:0] ul1_sel;
  } cacv_attr_t;

  typedef struct packed {
    logic pen_detect;
    logic out_en;
    logic blink_en;
    logic reverse_en;
  } cacv_cur_t;

  typedef struct packed {
    cacv_cur_t  cur2;
    cacv_cur_t  cur1;
    logic [1:0] duty;
    logic [4:0] rate;
  } cacv_cursor_t;

  // One character cell as presented by the row buffer side
  typedef struct packed {
    logic        valid;
    logic [14:0] word;
    logic [4:0]  scan_line;
    logic [4:0]  line_count;
    logic [4:0]  abs_line;
    logic        gpa;
    logic        reverse;
    logic        blank;
    logic        cur1;
    logic        cur2;
  } cacv_char_t;

  typedef struct packed {
    logic        valid;
    logic [14:0] data;
    logic [4:0]  line_count;
    logic        reverse;
    logic        blank;
  } cacv_video_t;
endpackage

// ==== dv/cacv_top_assertions.sv ====
// Checker for the character attribute and cursor video block.
// Assumes it is bound to cacv_top and sees only that module's ports.
module cacv_top_checker (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  srst,
  // Observed ports
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire cacv_pkg::cacv_char_t  char_in,
  input wire cacv_pkg::cacv_video_t video_out,
  input wire logic                  pen_cursor_mark
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // Slave never stalls and never errors
  property p_bus_okay; hreadyout && !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus stalled or errored");
  property p_cell_kept; char_in.valid |=> video_out.valid; endproperty
  a_cell_kept: assert property (p_cell_kept) else $error("cell dropped");
  property p_idle_zero; !char_in.valid |=> video_out == '0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("idle slot not zero");
  property p_blank_or; char_in.valid && char_in.blank |=> video_out.blank; endproperty
  a_blank_or: assert property (p_blank_or) else $error("input blank lost");
  // Either line mode gives the same count when both agree
  property p_line_same;
    char_in.valid && char_in.line_count == char_in.abs_line
      |=> video_out.line_count == $past(char_in.line_count);
  endproperty
  a_line_same: assert property (p_line_same) else $error("line count wrong");
  property p_low_data; char_in.valid |=> video_out.data[12:0] == $past(char_in.word[12:0]);
  endproperty
  a_low_data: assert property (p_low_data) else $error("data bits altered");
  property p_cur1_bit;
    char_in.valid && !char_in.cur1 && !char_in.word[14] |=> !video_out.data[14];
  endproperty
  a_cur1_bit: assert property (p_cur1_bit) else $error("bit 14 set with no cause");
  property p_cur2_bit;
    char_in.valid && !char_in.cur2 && !char_in.word[13] |=> !video_out.data[13];
  endproperty
  a_cur2_bit: assert property (p_cur2_bit) else $error("bit 13 set with no cause");
  property p_pen_mark;
    pen_cursor_mark |-> $past(char_in.valid) && $past(char_in.cur1 || char_in.cur2);
  endproperty
  a_pen_mark: assert property (p_pen_mark) else $error("pen mark off cursor");
endmodule

bind cacv_top cacv_top_checker u_chk (
  .clock(clock), .srst(srst), .hreadyout(hreadyout), .hresp(hresp),
  .char_in(char_in), .video_out(video_out), .pen_cursor_mark(pen_cursor_mark)
);

// ==== dv/cacv_pen_partner.sv ====
// Light pen sensor on the video side, as seen by the block.
// Assumes the bench aims the pen; output is not tied to the clock.
module cacv_pen_partner (
  // Aim from the bench
  input  wire logic pen_aim,
  // Sensor toward the block
  output logic      light_pen_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sensor lags the aim by an odd delay, so it lands off the clock edge
  initial light_pen_in = 1'h0;
  always @(pen_aim) light_pen_in <= #3 pen_aim;
endmodule

// ==== dv/char_attribute_cursor_video_test.sv ====
// Testbench for the character attribute and cursor video block.
// Assumes cacv_top, its bound checker and the light pen partner.
module char_attribute_cursor_video_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clock, srst, hsel, hwrite, frame_start, pen_aim, light_pen_in;
  logic                   hreadyout, hresp, pen_cursor_mark, cnt_mode, pen_seen;
  logic [31:0]            haddr, hwdata, hrdata, rd;
  logic [63:0]            r;
  logic [1:0]             htrans;
  logic [2:0]             hsize;
  logic [4:0]             l1, l2;
  cacv_pkg::cacv_char_t   char_in, c, fx;
  cacv_pkg::cacv_video_t  video_out, q[$];
  cacv_pkg::cacv_attr_t   at;
  cacv_pkg::cacv_cursor_t cu;
  int                     fail_count, checked, cycles, nb, nd, seed;

  cacv_top DUT (.clock(clock), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .frame_start(frame_start), .char_in(char_in),
    .light_pen_in(light_pen_in), .video_out(video_out), .pen_cursor_mark(pen_cursor_mark));
  cacv_pen_partner u_pen (.pen_aim(pen_aim), .light_pen_in(light_pen_in));

  // Clock of 8 ns
  initial
  begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Single word transfer; waits on hready in both phases
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge clock); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask

  function logic sb(input logic [3:0] s, input logic [14:0] w);
    return (s == 4'hf) ? 1'h0 : w[s];
  endfunction

  // Expected video for one cell with blinking off
  function cacv_pkg::cacv_video_t ev(input cacv_pkg::cacv_char_t x);
    logic u1, u2, iv;
    u1 = sb(at.ul1_sel, x.word) & (x.scan_line == l1);
    u2 = (at.ul2_sel != 4'hf) & (at.gpa_ul2 ? x.gpa : sb(at.ul2_sel, x.word))
       & (x.scan_line == l2);
    iv = sb(at.inv_sel, x.word);
    ev.valid = 1'h1;
    ev.blank = x.blank | u1 | u2 | iv | (x.cur1 & !cu.cur1.reverse_en)
             | (x.cur2 & !cu.cur2.reverse_en);
    ev.reverse = x.reverse ^ u1 ^ u2 ^ (x.cur1 & cu.cur1.reverse_en)
               ^ (x.cur2 & cu.cur2.reverse_en);
    ev.data = x.word;
    if (cu.cur1.out_en)
      ev.data[14] = x.cur1;
    if (cu.cur2.out_en)
      ev.data[13] = x.cur2;
    ev.line_count = sb(at.abs_sel, x.word) ? x.abs_line : x.line_count;
  endfunction

  // Stream of random or fixed cells; scan lines kept low to hit underlines
  task send(input int n, input logic rnd);
    repeat (n)
    begin
      @(posedge clock);
      r = {$random(seed), $random(seed)};
      c = rnd ? cacv_pkg::cacv_char_t'(r[35:0]) : fx;
      c.valid = 1'h1;
      c.scan_line[4:2] = 3'h0;
      char_in <= c;
      if (!cnt_mode)
        q.push_back(ev(c));
    end
    @(posedge clock);
    char_in <= '0;
  endtask

  task frame;
    @(posedge clock);
    frame_start <= 1'h1;
    @(posedge clock);
    frame_start <= 1'h0;
  endtask

  // Staged config only lands at the frame pulse
  task cfg(input logic [31:0] a, input logic [31:0] k);
    bus(1'h1, cacv_pkg::OFS_ATTR, a);
    bus(1'h1, cacv_pkg::OFS_CURSOR, k);
    frame;
    at = a[24:0];
    cu = {k[15:8], k[6:0]};
  endtask

  // Output watcher: compares against the oldest note
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      report_and_stop;
    end
    if (pen_cursor_mark === 1'h1)
      pen_seen = 1'h1;
    if (!srst && video_out.valid === 1'h1)
    begin
      if (cnt_mode)
      begin
        nb += video_out.blank;
        nd += video_out.data[14];
      end
      else if (q.size() == 0)
        chk(32'h0000_0001, 32'h0000_0000);
      else
        chk({9'h000, video_out}, {9'h000, q.pop_front()});
    end
  end

  initial
  begin
    {srst, hsel, hwrite, frame_start, pen_aim, cnt_mode, pen_seen} = 7'h40;
    {haddr, hwdata, htrans, l1, l2} = '0;
    hsize = 3'h2;
    char_in = '0;
    fx = '0;
    seed = 12115;
    at = cacv_pkg::ATTR_RST[24:0];
    cu = cacv_pkg::CURSOR_RST[14:0];
    repeat (16) @(posedge clock);
    srst <= 1'h0;
    bus(1'h0, cacv_pkg::OFS_ATTR, 32'h0000_0000);
    chk(rd, cacv_pkg::ATTR_RST);
    bus(1'h0, cacv_pkg::OFS_CURSOR, 32'h0000_0000);
    chk(rd, cacv_pkg::CURSOR_RST);
    bus(1'h0, 8'h40, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    send(30, 1'h1);
    $display("reset defaults done");
    bus(1'h1, cacv_pkg::OFS_ATTR, 32'h0000_9753);
    bus(1'h1, cacv_pkg::OFS_ROW, 32'h0000_0201);
    l1 = 5'h01;
    l2 = 5'h02;
    send(20, 1'h1);
    cfg(32'h0000_9753, 32'h0000_4500);
    send(80, 1'h1);
    cfg(32'h0100_9753, 32'h0000_4500);
    send(40, 1'h1);
    $display("attributes done");
    fx.word = 15'h0020;
    fx.scan_line = 5'h02;
    fx.cur1 = 1'h1;
    for (int d = 0; d < 4; d++)
    begin
      cfg(32'h0003_ff5f | (d << 22), 32'h0000_0701 | (d << 5));
      cnt_mode = 1'h1;
      nb = 0;
      nd = 0;
      repeat (4)
      begin
        frame;
        send(1, 1'h0);
      end
      repeat (2) @(posedge clock);
      cnt_mode = 1'h0;
      chk(32'(nb), 32'(d == 0 ? 4 : d));
      chk(32'(nd), 32'(d == 0 ? 4 : d));
    end
    $display("blinking done");
    fx.word = 15'h0000;
    fx.cur2 = 1'h1;
    cfg(32'h0000_ffff, 32'h0000_8800);
    pen_aim <= 1'h1;
    repeat (4) @(posedge clock);
    send(1, 1'h0);
    repeat (3) @(posedge clock);
    chk({31'h0, pen_seen}, 32'h0000_0001);
    bus(1'h0, cacv_pkg::OFS_STATUS, 32'h0000_0000);
    chk({30'h0, rd[1:0]}, 32'h0000_0003);
    pen_aim <= 1'h0;
    repeat (4) @(posedge clock);
    bus(1'h1, cacv_pkg::OFS_STATUS, 32'h0000_0003);
    bus(1'h0, cacv_pkg::OFS_STATUS, 32'h0000_0000);
    chk({30'h0, rd[1:0]}, 32'h0000_0000);
    $display("light pen done");
    repeat (4) @(posedge clock);
    chk(32'(q.size()), 32'h0000_0000);
    report_and_stop;
  end
endmodule
